// >>> verilog/dcp_dram.sv
// DRAM end: mode registers, bank rows, array and calibration readout.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module dcp_dram #(
  parameter int AL = 0,
  parameter int CL = 6,
  parameter int ROW_IDX_W = 1
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  dcp_link_if.dram link,
  output logic mpr_active_o,
  output logic [dcp_pkg::NBANK-1:0] bank_open_o,
  output logic cmd_err_o
);
  localparam int RL = AL + CL;
  localparam int DEPTH = RL - 1;
  localparam int MEM_AW = dcp_pkg::BA_W + ROW_IDX_W + 3;

  logic [1:0] bl_mode_r;
  logic [1:0] loc_r;
  logic [dcp_pkg::NBANK-1:0] ready;
  logic [dcp_pkg::NBANK-1:0] pre_load;
  logic [dcp_pkg::ADDR_W-1:0] row_r [dcp_pkg::NBANK];
  logic [dcp_pkg::DQ_W-1:0] mem_r [2**MEM_AW];
  dcp_pkg::dcp_rd_t pipe_r [DEPTH];
  dcp_pkg::dcp_rd_t rd_nxt;
  dcp_pkg::dcp_rd_t cur_r;
  logic [2:0] beat_r;
  logic [3:0] left_r;
  logic chop;
  logic rd_ok;
  logic wr_ok;
  logic act_ok;
  logic [2:0] ba;
  logic [dcp_pkg::COL_W-1:0] col;
  logic [7:0] pat;
  logic [2:0] pos;
  dcp_pkg::dcp_rd_t src;
  logic [2:0] beat;

  initial
  begin
    if (RL < 2) $error("dcp_dram needs additive plus column latency >= 2");
    // The read pipeline carries one row bit, so only one row bit can index.
    if (ROW_IDX_W != 1)
      $error("dcp_dram row index width must be 1");
  end

  assign ba = link.ba;
  // Address bit 12 is burst control only; the column is bits 9..0.
  assign col = link.addr[dcp_pkg::COL_W-1:0];

  always_comb
  begin
    case (bl_mode_r)
      dcp_pkg::BL_FIXED8: chop = 1'b0;
      dcp_pkg::BL_ONFLY: chop = ~link.addr[dcp_pkg::A_CHOP];
      dcp_pkg::BL_FIXED4: chop = 1'b1;
      default: chop = 1'b0;
    endcase
  end

  assign act_ok = ~mpr_active_o & ~bank_open_o[ba] & ready[ba];
  assign rd_ok = mpr_active_o | bank_open_o[ba];
  assign wr_ok = ~mpr_active_o & bank_open_o[ba];

  always_comb
  begin
    rd_nxt = '0;
    rd_nxt.vld = (link.cmd == dcp_pkg::CMD_RD) && rd_ok;
    rd_nxt.calibration_pattern_register = mpr_active_o;
    rd_nxt.loc = loc_r;
    rd_nxt.chop = chop;
    rd_nxt.ba = ba;
    rd_nxt.row0 = row_r[ba][0];
    if (mpr_active_o)
      rd_nxt.start = col[dcp_pkg::A_NIBBLE] ? dcp_pkg::NIBBLE_HI
                                            : dcp_pkg::NIBBLE_LO;
    else
      rd_nxt.start = col[2:0];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      mpr_active_o <= 1'b0;
      loc_r <= dcp_pkg::LOC_PATTERN;
      bl_mode_r <= dcp_pkg::BL_FIXED8;
    end
    else if (ce_i && link.cmd == dcp_pkg::CMD_MRS)
    begin
      if (ba == dcp_pkg::MR_THREE)
      begin
        mpr_active_o <= link.addr[dcp_pkg::MR3_EN_BIT];
        loc_r <= link.addr[dcp_pkg::MR3_LOC_LSB +: 2];
      end
      else if (ba == dcp_pkg::MR_ZERO)
        bl_mode_r <= link.addr[dcp_pkg::MR0_BL_LSB +: 2];
    end
  end

  // A precharge to an idle or closing bank simply reloads its timer.
  always_comb
  begin
    pre_load = '0;
    if (link.cmd == dcp_pkg::CMD_PRE)
    begin
      if (link.addr[dcp_pkg::A_AUTOCLOSE])
        pre_load = '1;
      else
        pre_load[ba] = 1'b1;
    end
    else if ((link.cmd == dcp_pkg::CMD_RD && !mpr_active_o && rd_ok)
             || (link.cmd == dcp_pkg::CMD_WR && wr_ok))
      pre_load[ba] = link.addr[dcp_pkg::A_AUTOCLOSE];
  end

  genvar g;
  generate
    for (g = 0; g < dcp_pkg::NBANK; g++)
    begin : g_bank
      dcp_timer #(.W(8)) u_rp (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .load_i(pre_load[g]),
        .load_val_i(dcp_pkg::RP_CYC),
        .done_o(ready[g])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      bank_open_o <= '0;
    else if (ce_i)
    begin
      if (link.cmd == dcp_pkg::CMD_ACT && act_ok)
        bank_open_o[ba] <= 1'b1;
      else
        bank_open_o <= bank_open_o & ~pre_load;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i && link.cmd == dcp_pkg::CMD_ACT && act_ok)
      row_r[ba] <= link.addr;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i && link.cmd == dcp_pkg::CMD_WR && wr_ok)
      mem_r[{ba, row_r[ba][ROW_IDX_W-1:0], col[2:0]}] <= link.wdata;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      cmd_err_o <= 1'b0;
    else if (ce_i)
      cmd_err_o <= (link.cmd == dcp_pkg::CMD_ACT && !act_ok)
                   || (link.cmd == dcp_pkg::CMD_RD && !rd_ok)
                   || (link.cmd == dcp_pkg::CMD_WR && !wr_ok);
  end

  // The latency line lets reads overlap, as back-to-back bursts need.
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        pipe_r[i] <= '0;
    end
    else if (ce_i)
    begin
      pipe_r[0] <= rd_nxt;
      for (int i = 1; i < DEPTH; i++)
        pipe_r[i] <= pipe_r[i-1];
    end
  end

  always_comb
  begin
    if (pipe_r[DEPTH-1].vld)
    begin
      src = pipe_r[DEPTH-1];
      beat = 3'h0;
    end
    else
    begin
      src = cur_r;
      beat = beat_r;
    end
    pos = src.start + beat;
    pat = (src.loc == dcp_pkg::LOC_PATTERN) ? dcp_pkg::PAT_CALIB
                                            : dcp_pkg::PAT_RESERVED;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      cur_r <= '0;
      beat_r <= 3'h0;
      left_r <= 4'h0;
    end
    else if (ce_i)
    begin
      if (pipe_r[DEPTH-1].vld)
      begin
        cur_r <= pipe_r[DEPTH-1];
        beat_r <= 3'h1;
        left_r <= pipe_r[DEPTH-1].chop ? 4'(dcp_pkg::BURST4 - 1)
                                       : 4'(dcp_pkg::BURST8 - 1);
      end
      else if (left_r != 4'h0)
      begin
        beat_r <= beat_r + 3'h1;
        left_r <= left_r - 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      link.dq <= '0;
      link.dq_valid <= 1'b0;
      link.dqs <= 1'b0;
    end
    else if (ce_i)
    begin
      link.dq_valid <= pipe_r[DEPTH-1].vld || left_r != 4'h0;
      link.dqs <= (pipe_r[DEPTH-1].vld || left_r != 4'h0) & ~link.dqs;
      if (src.calibration_pattern_register)
        link.dq <= {dcp_pkg::DQ_W{pat[pos]}};
      else
        link.dq <= mem_r[{src.ba, ROW_IDX_W'(src.row0), pos}];
    end
  end
endmodule
`default_nettype wire

// >>> verilog/dcp_pkg.sv
// Shared constants and types for the calibration-pattern DRAM link.
`default_nettype none
package dcp_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_ACT, CMD_PRE,
                            CMD_RD, CMD_WR} dcp_cmd_t;
  localparam int NBANK = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 13;
  localparam int DQ_W = 16;
  localparam int LANE_W = 8;
  localparam int BURST8 = 8;
  localparam int BURST4 = 4;
  // Mode register selection on the bank address during a mode write.
  localparam logic [2:0] MR_ZERO = 3'h0;
  localparam logic [2:0] MR_THREE = 3'h3;
  localparam int MR3_EN_BIT = 2;
  localparam int MR3_LOC_LSB = 0;
  localparam int MR0_BL_LSB = 0;
  localparam int A_AUTOCLOSE = 10;
  localparam int A_CHOP = 12;
  localparam int A_NIBBLE = 2;
  localparam int COL_W = 10;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_ONFLY = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [2:0] NIBBLE_LO = 3'h0;
  localparam logic [2:0] NIBBLE_HI = 3'h4;
  // Position 0 is the least significant bit: pattern 0,1,0,1,0,1,0,1.
  localparam logic [7:0] PAT_CALIB = 8'haa;
  localparam logic [7:0] PAT_RESERVED = 8'h00;
  // Timing figures in nanoseconds and the clock they are counted on.
  localparam int CLK_NS = 40;
  localparam int T_RP_NS = 15;
  localparam int T_MRD_NS = 160;
  localparam int T_MOD_NS = 480;
  localparam int T_MPRR_NS = 40;
  localparam int WR_GAP_CYC = 8;
  localparam logic [7:0] RP_CYC = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] MRD_CYC = 8'((T_MRD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] MOD_CYC = 8'((T_MOD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] MPRR_CYC = 8'((T_MPRR_NS + CLK_NS - 1) / CLK_NS);
  // Controller register offsets and command word fields.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CAP = 8'h08;
  localparam int CW_OP_LSB = 0;
  localparam int CW_BA_LSB = 4;
  localparam int CW_ADDR_LSB = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_MPR = 2;
  localparam int ST_OPEN_LSB = 8;
  typedef struct packed {
    logic vld;
    logic calibration_pattern_register;
    logic [1:0] loc;
    logic chop;
    logic [2:0] start;
    logic [2:0] ba;
    logic row0;
  } dcp_rd_t;
endpackage
`default_nettype wire

// >>> verilog/dcp_link_if.sv
// Command, address and read data link between controller and DRAM.
`timescale 1ns/1ns
`default_nettype none
interface dcp_link_if;
  dcp_pkg::dcp_cmd_t cmd;
  logic [dcp_pkg::BA_W-1:0] ba;
  logic [dcp_pkg::ADDR_W-1:0] addr;
  logic [dcp_pkg::DQ_W-1:0] wdata;
  logic [dcp_pkg::DQ_W-1:0] dq;
  logic dq_valid;
  logic dqs;
  modport dram (input cmd, ba, addr, wdata, output dq, dq_valid, dqs);
  modport ctrl (output cmd, ba, addr, wdata, input dq, dq_valid, dqs);
endinterface
`default_nettype wire

// >>> verilog/dcp_timer.sv
// Loadable countdown timer; done while the count is zero.
`timescale 1ns/1ns
`default_nettype none
module dcp_timer #(
  parameter int W = 8
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  output logic done_o
);
  logic [W-1:0] cnt_r;

  initial
  begin
    if (W < 1) $error("dcp_timer width must be at least 1");
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      cnt_r <= '0;
    else if (ce_i)
    begin
      if (load_i)
        cnt_r <= load_val_i;
      else if (cnt_r != '0)
        cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done_o = (cnt_r == '0);
endmodule
`default_nettype wire

// >>> verilog/dcp_ctrl.sv
// Controller end: register port, command sequencing and read capture.
`timescale 1ns/1ns
`default_nettype none
module dcp_ctrl #(
  parameter int AL = 0,
  parameter int CL = 6
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic dll_locked_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  dcp_link_if.ctrl link
);
  localparam int RL = AL + CL;
  localparam logic [7:0] RD_CYC = 8'(RL + dcp_pkg::BURST8);
  localparam logic [7:0] SET_CYC = (dcp_pkg::MRD_CYC > dcp_pkg::MOD_CYC)
                                   ? dcp_pkg::MRD_CYC : dcp_pkg::MOD_CYC;
  typedef enum logic {C_IDLE, C_WAIT} dcp_cst_t;

  dcp_cst_t state_r;
  logic [dcp_pkg::NBANK-1:0] open_r;
  logic mpr_r;
  logic err_r;
  logic [7:0] cap_r;
  logic go;
  logic legal;
  logic load;
  logic [7:0] wait_val;
  logic done;
  dcp_pkg::dcp_cmd_t op;
  logic [2:0] ba;
  logic [dcp_pkg::ADDR_W-1:0] addr;
  logic [dcp_pkg::ADDR_W-1:0] addr_out;

  initial
  begin
    if (RL < 2 || RL + dcp_pkg::BURST8 + 2 > 255)
      $error("dcp_ctrl latency out of range");
  end

  assign op = dcp_pkg::dcp_cmd_t'(reg_wdata_i[dcp_pkg::CW_OP_LSB +: 3]);
  assign ba = reg_wdata_i[dcp_pkg::CW_BA_LSB +: 3];
  assign addr = reg_wdata_i[dcp_pkg::CW_ADDR_LSB +: dcp_pkg::ADDR_W];
  assign go = reg_wr_i && reg_addr_i == dcp_pkg::REG_CMD;

  always_comb
  begin
    legal = 1'b1;
    case (op)
      dcp_pkg::CMD_ACT: legal = !mpr_r && !open_r[ba];
      dcp_pkg::CMD_WR: legal = !mpr_r && open_r[ba];
      dcp_pkg::CMD_RD: legal = mpr_r ? dll_locked_i : open_r[ba];
      dcp_pkg::CMD_MRS: legal = open_r == '0;
      dcp_pkg::CMD_PRE: legal = !mpr_r;
      default: legal = 1'b1;
    endcase
  end

  // In readout mode the low column bits are forced to zero.
  always_comb
  begin
    addr_out = addr;
    if (op == dcp_pkg::CMD_RD && mpr_r)
      addr_out[1:0] = 2'h0;
  end

  always_comb
  begin
    case (op)
      dcp_pkg::CMD_PRE: wait_val = dcp_pkg::RP_CYC;
      dcp_pkg::CMD_MRS: wait_val = SET_CYC;
      dcp_pkg::CMD_RD: wait_val = mpr_r ? RD_CYC + dcp_pkg::MPRR_CYC
                                        : RD_CYC;
      dcp_pkg::CMD_WR: wait_val = 8'(dcp_pkg::WR_GAP_CYC);
      default: wait_val = 8'h1;
    endcase
  end

  assign load = ce_i && go && state_r == C_IDLE && legal;

  dcp_timer #(.W(8)) u_wait (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .load_i(load),
    .load_val_i(wait_val),
    .done_o(done)
  );

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      state_r <= C_IDLE;
    else if (ce_i)
    begin
      case (state_r)
        C_IDLE: if (load) state_r <= C_WAIT;
        C_WAIT: if (done) state_r <= C_IDLE;
        default: state_r <= C_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      link.cmd <= dcp_pkg::CMD_NOP;
      link.ba <= '0;
      link.addr <= '0;
      link.wdata <= '0;
    end
    else if (ce_i)
    begin
      link.cmd <= load ? op : dcp_pkg::CMD_NOP;
      if (load)
      begin
        link.ba <= ba;
        link.addr <= addr_out;
        link.wdata <= reg_wdata_i[dcp_pkg::DQ_W-1:0];
      end
    end
  end

  // Tracks bank and mode state exactly as the DRAM will see it.
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      open_r <= '0;
      mpr_r <= 1'b0;
    end
    else if (load)
    begin
      case (op)
        dcp_pkg::CMD_ACT: open_r[ba] <= 1'b1;
        dcp_pkg::CMD_PRE:
          if (addr[dcp_pkg::A_AUTOCLOSE])
            open_r <= '0;
          else
            open_r[ba] <= 1'b0;
        dcp_pkg::CMD_RD, dcp_pkg::CMD_WR:
          if (addr[dcp_pkg::A_AUTOCLOSE] && !mpr_r)
            open_r[ba] <= 1'b0;
        dcp_pkg::CMD_MRS:
          if (ba == dcp_pkg::MR_THREE)
            mpr_r <= addr[dcp_pkg::MR3_EN_BIT];
        default: open_r <= open_r;
      endcase
    end
  end

  // Error is sticky; a refused command in the clearing cycle still sets it.
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      err_r <= 1'b0;
    else if (ce_i)
    begin
      if (go && (state_r != C_IDLE || !legal))
        err_r <= 1'b1;
      else if (reg_wr_i && reg_addr_i == dcp_pkg::REG_STAT)
        err_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      cap_r <= 8'h00;
    else if (ce_i && link.dq_valid)
      cap_r <= {link.dq[0], cap_r[7:1]};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h0;
    else if (ce_i)
    begin
      reg_rdata_o <= 32'h0;
      if (reg_rd_i && reg_addr_i == dcp_pkg::REG_STAT)
      begin
        reg_rdata_o[dcp_pkg::ST_BUSY] <= state_r != C_IDLE;
        reg_rdata_o[dcp_pkg::ST_ERR] <= err_r;
        reg_rdata_o[dcp_pkg::ST_MPR] <= mpr_r;
        reg_rdata_o[dcp_pkg::ST_OPEN_LSB +: dcp_pkg::NBANK] <= open_r;
      end
      else if (reg_rd_i && reg_addr_i == dcp_pkg::REG_CAP)
        reg_rdata_o[7:0] <= cap_r;
    end
  end
endmodule
`default_nettype wire

// >>> verif/dcp_link_assertions.sv
// Protocol assertions on the link between controller and DRAM ends.
`timescale 1ns/1ns
`default_nettype none
module dcp_link_assertions (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input var dcp_pkg::dcp_cmd_t cmd,
  input wire logic [dcp_pkg::BA_W-1:0] ba,
  input wire logic [dcp_pkg::ADDR_W-1:0] addr,
  input wire logic [dcp_pkg::DQ_W-1:0] dq,
  input wire logic dq_valid,
  input wire logic dqs,
  input wire logic mpr_active_o,
  input wire logic cmd_err_o
);
  logic [1:0] mode_r;
  logic [1:0] loc_r;
  logic [7:0] gap_r;
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      mode_r <= dcp_pkg::BL_FIXED8;
    else if (cmd == dcp_pkg::CMD_MRS && ba == dcp_pkg::MR_ZERO)
      mode_r <= addr[1:0];
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      loc_r <= dcp_pkg::LOC_PATTERN;
    else if (cmd == dcp_pkg::CMD_MRS && ba == dcp_pkg::MR_THREE)
      loc_r <= addr[1:0];
  end
  // Cycles since the last mode write; saturates so old writes never wrap.
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      gap_r <= 8'hff;
    else if (cmd == dcp_pkg::CMD_MRS)
      gap_r <= 8'h01;
    else if (gap_r != 8'hff)
      gap_r <= gap_r + 8'h01;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  read_latency_a: assert property (cmd == dcp_pkg::CMD_RD
    |-> ##5 !dq_valid ##1 dq_valid) else $error("read data late or early");
  full_burst_a: assert property (cmd == dcp_pkg::CMD_RD &&
    (mode_r == dcp_pkg::BL_FIXED8 || (mode_r == dcp_pkg::BL_ONFLY && addr[12]))
    |-> ##6 dq_valid [*8] ##1 !dq_valid) else $error("full burst length");
  chop_burst_a: assert property (cmd == dcp_pkg::CMD_RD &&
    (mode_r == dcp_pkg::BL_FIXED4
     || (mode_r == dcp_pkg::BL_ONFLY && !addr[12]))
    |-> ##6 dq_valid [*4] ##1 !dq_valid) else $error("chopped burst length");
  lane_copy_a: assert property (mpr_active_o && dq_valid
    |-> dq == {16{dq[0]}}) else $error("lane bits differ");
  strobe_toggle_a: assert property (dqs == (dq_valid && !$past(dqs)))
    else $error("strobe does not follow beats");
  first_beat_a: assert property (mpr_active_o && loc_r == 2'h0
    && $rose(dq_valid) |-> dq == 16'h0000) else $error("first beat wrong");
  pattern_alt_a: assert property (mpr_active_o && loc_r == 2'h0
    && dq_valid && $past(dq_valid) |-> dq[0] != $past(dq[0]))
    else $error("pattern does not alternate");
  reserved_zero_a: assert property (mpr_active_o && loc_r != 2'h0
    && dq_valid |-> dq == 16'h0000) else $error("reserved data not zero");
  no_write_a: assert property (mpr_active_o
    |-> cmd != dcp_pkg::CMD_WR) else $error("write during readout");
  mode_settle_a: assert property (cmd != dcp_pkg::CMD_NOP
    |-> gap_r >= dcp_pkg::MOD_CYC) else $error("command too soon");
  read_recovery_a: assert property (cmd == dcp_pkg::CMD_MRS
    |-> !dq_valid && !$past(dq_valid)) else $error("mode write in burst");
  no_refusal_a: assert property (!cmd_err_o)
    else $error("illegal command reached the DRAM");
endmodule
`default_nettype wire

// >>> verif/test_dram_calib_pattern_read_and_row_cmds.sv
// Self-checking bench for the controller and DRAM ends joined by the link.
`timescale 1ns/1ns
`default_nettype none
module test_dram_calib_pattern_read_and_row_cmds;
  logic sys_clk_i;
  logic sys_rst_i;
  logic dll_locked_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic mpr_active_o;
  logic [7:0] bank_open_o;
  logic cmd_err_o;
  logic chk;
  logic chk_d;
  logic ce;
  logic [63:0] note;
  logic [31:0] last;
  logic [16:0] seed;
  logic [2:0] b;
  logic [2:0] wop;
  logic [63:0] q[$];
  int bad_count;
  int num_checks;
  dcp_link_if u_dcp_link_if ();
  dcp_ctrl u_dcp_ctrl (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce), .dll_locked_i(dll_locked_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .link(u_dcp_link_if));
  dcp_dram u_dcp_dram (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce), .link(u_dcp_link_if), .mpr_active_o(mpr_active_o),
    .bank_open_o(bank_open_o), .cmd_err_o(cmd_err_o));
  dcp_link_assertions u_dcp_link_assertions (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .cmd(u_dcp_link_if.cmd), .ba(u_dcp_link_if.ba),
    .addr(u_dcp_link_if.addr), .dq(u_dcp_link_if.dq),
    .dq_valid(u_dcp_link_if.dq_valid), .dqs(u_dcp_link_if.dqs),
    .mpr_active_o(mpr_active_o), .cmd_err_o(cmd_err_o));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    lfsr = {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // A zero mask marks a status poll whose value is not compared.
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    chk <= (m != 32'h0);
    if (m != 32'h0)
      q.push_back({m, e});
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    chk <= 1'b0;
    #1 last = reg_rdata_o;
    @(posedge sys_clk_i);
  endtask
  task automatic op(input dcp_pkg::dcp_cmd_t c, input logic [2:0] ba,
                    input logic [12:0] a);
    int n;
    wr(dcp_pkg::REG_CMD, {3'h0, a, 9'h0, ba, 1'b0, c});
    n = 0;
    last = 32'h1;
    while (last[dcp_pkg::ST_BUSY] !== 1'b0 && n < 100)
    begin
      rd(dcp_pkg::REG_STAT, 32'h0, 32'h0);
      n++;
    end
    if (n == 100)
    begin
      bad_count++;
      $display("FAIL %0t command never finished", $time);
    end
  endtask
  // Results appear one cycle after the read strobe; oldest note first.
  always @(posedge sys_clk_i)
  begin
    if (chk_d)
    begin
      num_checks++;
      if (q.size() == 0)
      begin
        bad_count++;
        $display("FAIL %0t read result with no note", $time);
      end
      else
      begin
        note = q.pop_front();
        if ((reg_rdata_o & note[63:32]) !== (note[31:0] & note[63:32]))
        begin
          bad_count++;
          $display("FAIL %0t register read gave %h", $time, reg_rdata_o);
        end
      end
    end
    chk_d <= !sys_rst_i && reg_rd_i && chk;
  end
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    bad_count++;
    summarize();
  end
  initial
  begin
    sys_rst_i = 1'b1;
    dll_locked_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    chk = 1'b0;
    ce = 1'b1;
    seed = 17'h15414;
    wop = dcp_pkg::CMD_WR;
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(dcp_pkg::REG_STAT, 32'hffffffff, 32'h0);
    rd(8'h0c, 32'hffffffff, 32'h0);
    seed = lfsr(seed);
    b = seed[2:0];
    op(dcp_pkg::CMD_ACT, b, seed[15:3]);
    rd(dcp_pkg::REG_STAT, 32'hff06, {16'h0, 8'h01 << b, 8'h0});
    op(dcp_pkg::CMD_ACT, b, 13'h0);
    rd(dcp_pkg::REG_STAT, 32'h2, 32'h2);
    wr(dcp_pkg::REG_STAT, 32'h0);
    for (int i = 0; i < 8; i++)
      op(dcp_pkg::CMD_WR, b, {1'b1, 9'h0, i[2:0]});
    op(dcp_pkg::CMD_RD, b, {1'b1, 1'b0, 1'b1, 7'h0, 3'h3});
    rd(dcp_pkg::REG_STAT, 32'hff00, 32'h0);
    rd(dcp_pkg::REG_CAP, 32'hff, {24'h0, {8{wop[0]}}});
    op(dcp_pkg::CMD_PRE, b, 13'h0);
    op(dcp_pkg::CMD_PRE, b, 13'h0);
    rd(dcp_pkg::REG_STAT, 32'hff02, 32'h0);
    op(dcp_pkg::CMD_RD, b, 13'h1000);
    rd(dcp_pkg::REG_STAT, 32'h2, 32'h2);
    wr(dcp_pkg::REG_STAT, 32'h0);
    op(dcp_pkg::CMD_ACT, 3'h1, 13'h0);
    op(dcp_pkg::CMD_MRS, dcp_pkg::MR_THREE, 13'h4);
    rd(dcp_pkg::REG_STAT, 32'h6, 32'h2);
    wr(dcp_pkg::REG_STAT, 32'h0);
    op(dcp_pkg::CMD_PRE, 3'h0, 13'h0400);
    op(dcp_pkg::CMD_MRS, dcp_pkg::MR_ZERO, {11'h0, dcp_pkg::BL_ONFLY});
    op(dcp_pkg::CMD_MRS, dcp_pkg::MR_THREE, 13'h4);
    rd(dcp_pkg::REG_STAT, 32'hff06, 32'h4);
    op(dcp_pkg::CMD_RD, 3'h5, 13'h1400);
    rd(dcp_pkg::REG_CAP, 32'hff, 32'haa);
    op(dcp_pkg::CMD_RD, 3'h0, 13'h0000);
    rd(dcp_pkg::REG_CAP, 32'hf0, 32'ha0);
    op(dcp_pkg::CMD_RD, 3'h0, 13'h0004);
    rd(dcp_pkg::REG_CAP, 32'hf0, 32'ha0);
    op(dcp_pkg::CMD_WR, 3'h0, 13'h1000);
    rd(dcp_pkg::REG_STAT, 32'h6, 32'h6);
    wr(dcp_pkg::REG_STAT, 32'h0);
    dll_locked_i <= 1'b0;
    op(dcp_pkg::CMD_RD, 3'h0, 13'h1000);
    rd(dcp_pkg::REG_STAT, 32'h2, 32'h2);
    wr(dcp_pkg::REG_STAT, 32'h0);
    dll_locked_i <= 1'b1;
    for (int i = 1; i < 4; i++)
    begin
      op(dcp_pkg::CMD_MRS, dcp_pkg::MR_THREE, {10'h0, 1'b1, i[1:0]});
      op(dcp_pkg::CMD_RD, 3'h2, 13'h1000);
      rd(dcp_pkg::REG_CAP, 32'hff, 32'h0);
    end
    op(dcp_pkg::CMD_MRS, dcp_pkg::MR_THREE, 13'h4);
    op(dcp_pkg::CMD_MRS, dcp_pkg::MR_ZERO, {11'h0, dcp_pkg::BL_FIXED4});
    op(dcp_pkg::CMD_RD, 3'h0, 13'h1000);
    rd(dcp_pkg::REG_CAP, 32'hff, 32'ha0);
    op(dcp_pkg::CMD_MRS, dcp_pkg::MR_THREE, 13'h0);
    op(dcp_pkg::CMD_ACT, 3'h1, 13'h2);
    rd(dcp_pkg::REG_STAT, 32'hff06, 32'h0200);
    // A command offered while the clock enable is low must leave no trace.
    ce <= 1'b0;
    wr(dcp_pkg::REG_CMD, {16'h0, 9'h0, 3'h3, 1'b0, dcp_pkg::CMD_ACT});
    ce <= 1'b1;
    rd(dcp_pkg::REG_STAT, 32'hff07, 32'h0200);
    num_checks++;
    if (bank_open_o !== 8'h02)
    begin
      bad_count++;
      $display("FAIL %0t DRAM open banks differ", $time);
    end
    // Let the comparing process take the last note before the verdict.
    @(posedge sys_clk_i);
    summarize();
  end
endmodule
`default_nettype wire
